// [design/pps_prog_port_select.sv]
// Programming port pin selector: scan port or two-wire bus on shared pins
`timescale 1ns/1ns
module pps_prog_port_select #(
  parameter int unsigned IR_W  = pps_pkg::IR_W,
  parameter int unsigned CFG_W = pps_pkg::CFG_W
) (
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_b_i,
  input  wire logic                        sel_i,
  input  wire logic                        scan_reset_b_i,
  input  wire logic                        scan_clock_in_i,
  input  wire logic                        mode_pin_i,
  input  wire logic                        din_pin_i,
  input  wire logic [1:0]                  slave_addr_strap_hi_i,
  input  wire logic                        twi_sda_pull_i,
  output logic                             dout_pin_o,
  output logic                             dout_pin_oe_o,
  output logic                             sda_pin_o,
  output logic                             sda_pin_oe_o,
  output logic                             jtag_mode_o,
  output logic                             twi_scl_o,
  output logic                             twi_sda_o,
  output logic [pps_pkg::ADDR_W-1:0]       slave_addr_o,
  output logic [CFG_W-1:0]                 cfg_data_o,
  output logic                             cfg_load_o
);

  // ==========================================================================
  // Pin synchronisers: three stages, a change counts when stages two and three agree
  logic [pps_pkg::SYNC_W-1:0] sync1_ff;
  logic [pps_pkg::SYNC_W-1:0] sync2_ff;
  logic [pps_pkg::SYNC_W-1:0] sync3_ff;
  logic [pps_pkg::SYNC_W-1:0] filt_ff;
  logic [pps_pkg::SYNC_W-1:0] pins_raw;
  logic [pps_pkg::SYNC_W-1:0] pin_chg;

  assign pins_raw = {slave_addr_strap_hi_i, din_pin_i, mode_pin_i, scan_clock_in_i, sel_i};

  genvar gi;
  generate
    for (gi = 0; gi < pps_pkg::SYNC_W; gi++)
    begin : g_sync
      assign pin_chg[gi] = (sync2_ff[gi] == sync3_ff[gi]) && (sync3_ff[gi] != filt_ff[gi]);
      always_ff @(posedge ref_clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
          sync3_ff[gi] <= 1'b0;
          filt_ff[gi]  <= 1'b0;
        end
        else
        begin
          sync1_ff[gi] <= pins_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
          sync3_ff[gi] <= sync2_ff[gi];
          if (pin_chg[gi])
            filt_ff[gi] <= sync3_ff[gi];
        end
      end
    end
  endgenerate

  wire       sel_f    = filt_ff[pps_pkg::PIN_SEL];
  wire       tck_rise = pin_chg[pps_pkg::PIN_CLK] && sync3_ff[pps_pkg::PIN_CLK];
  wire       tck_fall = pin_chg[pps_pkg::PIN_CLK] && !sync3_ff[pps_pkg::PIN_CLK];
  // Data pins are taken from stage three so they line up with the clock edge
  wire       tdi_s    = sync3_ff[pps_pkg::PIN_DIN];
  wire       tms_s    = sync3_ff[pps_pkg::PIN_MODE];
  wire [1:0] strap_hi = filt_ff[pps_pkg::PIN_STRAP+1:pps_pkg::PIN_STRAP];

  // ==========================================================================
  // Scan reset: asserted at once by any source, released in step with the clock
  logic rrel1_ff;
  logic rrel2_ff;
  wire  tap_async_b = rst_b_i && scan_reset_b_i && sel_i;

  always_ff @(posedge ref_clk_i or negedge tap_async_b)
  begin
    if (!tap_async_b)
    begin
      rrel1_ff <= 1'b0;
      rrel2_ff <= 1'b0;
    end
    else
    begin
      rrel1_ff <= 1'b1;
      rrel2_ff <= rrel1_ff;
    end
  end

  wire tap_rst_b = rrel2_ff;

  // ==========================================================================
  // Scan controller
  pps_tap_if tap ();
  assign tap.tck_rise  = tck_rise;
  assign tap.tms       = tms_s;
  assign tap.tap_rst_b = tap_rst_b;

  pps_tap_fsm u_tap (
    .ref_clk_i (ref_clk_i),
    .tap       (tap.ctrl)
  );

  wire st_shift_ir = tap.state == pps_pkg::TAP_SHIFT_IR;
  wire st_shift_dr = tap.state == pps_pkg::TAP_SHIFT_DR;
  wire st_cap_ir   = tap.state == pps_pkg::TAP_CAP_IR;
  wire st_cap_dr   = tap.state == pps_pkg::TAP_CAP_DR;
  wire st_upd_ir   = tap.state == pps_pkg::TAP_UPD_IR;
  wire st_upd_dr   = tap.state == pps_pkg::TAP_UPD_DR;
  wire st_reset    = tap.state == pps_pkg::TAP_RESET;

  // ==========================================================================
  // Instruction, bypass and configuration shift paths
  logic [IR_W-1:0]  ir_sh_ff;
  logic [IR_W-1:0]  ir_ff;
  logic [CFG_W-1:0] cfg_sh_ff;
  logic             byp_ff;
  logic             dout_ff;
  logic             dout_oe_ff;
  logic [CFG_W-1:0] cfg_ff;
  logic             cfg_load_ff;

  wire prog_sel  = ir_ff == IR_W'(pps_pkg::IR_PROG);
  wire shift_bit = st_shift_ir ? ir_sh_ff[0] : (prog_sel ? cfg_sh_ff[0] : byp_ff);

  always_ff @(posedge ref_clk_i or negedge tap_rst_b)
  begin
    if (!tap_rst_b)
    begin
      ir_sh_ff  <= IR_W'(pps_pkg::IR_CAPTURE);
      cfg_sh_ff <= CFG_W'(pps_pkg::CFG_RST);
      byp_ff    <= 1'b0;
    end
    else if (tck_rise)
    begin
      if (st_cap_ir)
        ir_sh_ff <= IR_W'(pps_pkg::IR_CAPTURE);
      else if (st_shift_ir)
        ir_sh_ff <= {tdi_s, ir_sh_ff[IR_W-1:1]};
      if (st_cap_dr)
      begin
        cfg_sh_ff <= cfg_ff;
        byp_ff    <= 1'b0;
      end
      else if (st_shift_dr)
      begin
        if (prog_sel)
          cfg_sh_ff <= {tdi_s, cfg_sh_ff[CFG_W-1:1]};
        else
          byp_ff <= tdi_s;
      end
    end
  end

  // Updates and the output pin act on the falling scan edge
  always_ff @(posedge ref_clk_i or negedge tap_rst_b)
  begin
    if (!tap_rst_b)
    begin
      ir_ff      <= IR_W'(pps_pkg::IR_BYPASS);
      dout_ff    <= 1'b0;
      dout_oe_ff <= 1'b0;
    end
    else if (tck_fall)
    begin
      if (st_upd_ir)
        ir_ff <= ir_sh_ff;
      else if (st_reset)
        ir_ff <= IR_W'(pps_pkg::IR_BYPASS);
      dout_oe_ff <= st_shift_ir || st_shift_dr;
      if (st_shift_ir || st_shift_dr)
        dout_ff <= shift_bit;
    end
  end

  // Loaded configuration survives scan resets; only the chip reset clears it
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cfg_ff      <= CFG_W'(pps_pkg::CFG_RST);
      cfg_load_ff <= 1'b0;
    end
    else
    begin
      cfg_load_ff <= tap_rst_b && tck_fall && st_upd_dr && prog_sel;
      if (tap_rst_b && tck_fall && st_upd_dr && prog_sel)
        cfg_ff <= cfg_sh_ff;
    end
  end

  // ==========================================================================
  // Two-wire routing and strap address
  logic                      scl_ff;
  logic                      sda_ff;
  logic                      sda_oe_ff;
  logic                      mode_ff;
  logic [pps_pkg::ADDR_W-1:0] addr_ff;

  // An unused receiver code reads as the top level rather than aliasing low
  wire [1:0] hi_code = (strap_hi == pps_pkg::STRAP_LOW || strap_hi == pps_pkg::STRAP_MID)
                       ? strap_hi : pps_pkg::STRAP_HIGH;
  wire [pps_pkg::ADDR_W-1:0] addr_nxt = {hi_code, filt_ff[pps_pkg::PIN_MODE]};

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      scl_ff    <= 1'b1;
      sda_ff    <= 1'b1;
      sda_oe_ff <= 1'b0;
      mode_ff   <= 1'b0;
      addr_ff   <= '0;
    end
    else
    begin
      mode_ff   <= sel_f;
      scl_ff    <= sel_f ? 1'b1 : filt_ff[pps_pkg::PIN_CLK];
      sda_ff    <= sel_f ? 1'b1 : filt_ff[pps_pkg::PIN_DIN];
      sda_oe_ff <= !sel_f && twi_sda_pull_i;
      if (!sel_f)
        addr_ff <= addr_nxt;
    end
  end

  assign dout_pin_o    = dout_ff;
  assign dout_pin_oe_o = dout_oe_ff;
  assign sda_pin_o     = 1'b0;
  assign sda_pin_oe_o  = sda_oe_ff;
  assign jtag_mode_o   = mode_ff;
  assign twi_scl_o     = scl_ff;
  assign twi_sda_o     = sda_ff;
  assign slave_addr_o  = addr_ff;
  assign cfg_data_o    = cfg_ff;
  assign cfg_load_o    = cfg_load_ff;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  scan_mode_route_a: assert property (sel_f |=> jtag_mode_o && twi_scl_o && twi_sda_o)
    else $error("scan mode did not park the two-wire side");
  twi_reset_tap_a: assert property (!sel_f |-> tap.state == pps_pkg::TAP_RESET)
    else $error("scan controller not reset in two-wire mode");
  // A scan reset clears the pin at once; only moves outside reset must follow a fall
  dout_fall_only_a: assert property (tap_rst_b
      && ($changed(dout_pin_o) || $rose(dout_pin_oe_o)) |-> $past(tck_fall))
    else $error("scan output moved without a falling scan edge");
  dout_idle_hiz_a: assert property (dout_pin_oe_o && tck_fall && tap_rst_b
      && !st_shift_ir && !st_shift_dr |=> !dout_pin_oe_o)
    else $error("scan output driven while not shifting");
  ir_sample_a: assert property (tck_rise && st_shift_ir && tap_rst_b
      |=> ir_sh_ff[IR_W-1] == $past(tdi_s))
    else $error("scan input not sampled on rise");
  state_on_rise_a: assert property ($changed(tap.state) && $past(tap_rst_b) && tap_rst_b
      |-> $past(tck_rise))
    else $error("controller moved without a rising scan edge");
  scan_rst_a: assert property (!scan_reset_b_i |=> tap.state == pps_pkg::TAP_RESET
      && !dout_pin_oe_o)
    else $error("scan reset did not act");
  addr_form_a: assert property (!sel_f |=> slave_addr_o == $past(addr_nxt))
    else $error("slave address not taken from straps");
  scl_route_a: assert property (!sel_f |=> twi_scl_o == $past(filt_ff[pps_pkg::PIN_CLK]))
    else $error("serial clock not routed in two-wire mode");
  sda_route_a: assert property (!sel_f |=> twi_sda_o == $past(filt_ff[pps_pkg::PIN_DIN])
      && sda_pin_oe_o == $past(twi_sda_pull_i))
    else $error("serial data not routed in two-wire mode");
  addr_hold_a: assert property (sel_f |=> $stable(slave_addr_o))
    else $error("straps decoded in scan mode");

  cov_ir_update: cover property (tck_fall && st_upd_ir && tap_rst_b);
  cov_cfg_load: cover property (cfg_load_o);
  cov_dout_drive: cover property ($rose(dout_pin_oe_o));
  cov_sda_pull: cover property (sda_pin_oe_o);

endmodule : pps_prog_port_select

// [design/pps_pkg.sv]
// Shared constants and types for the programming port pin selector
package pps_pkg;

  // ==========================================================================
  // Scan path geometry and codes
  localparam int unsigned IR_W        = 4;
  localparam logic [3:0]  IR_CAPTURE  = 4'h1;
  localparam logic [3:0]  IR_BYPASS   = 4'hf;
  localparam logic [3:0]  IR_PROG     = 4'h2;
  localparam int unsigned CFG_W       = 8;
  localparam logic [7:0]  CFG_RST     = 8'h00;

  // ==========================================================================
  // Strap coding from the three-level receiver on the scan output pin
  localparam int unsigned ADDR_W      = 3;
  localparam logic [1:0]  STRAP_LOW   = 2'h0;
  localparam logic [1:0]  STRAP_MID   = 2'h1;
  localparam logic [1:0]  STRAP_HIGH  = 2'h2;

  // ==========================================================================
  // Pin synchroniser layout
  localparam int unsigned SYNC_W      = 6;
  localparam int unsigned PIN_SEL     = 0;
  localparam int unsigned PIN_CLK     = 1;
  localparam int unsigned PIN_MODE    = 2;
  localparam int unsigned PIN_DIN     = 3;
  localparam int unsigned PIN_STRAP   = 4;
  localparam logic [5:0]  SYNC_RST    = 6'h00;

  // ==========================================================================
  // Scan controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
    TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } pps_tap_state_t;

endpackage : pps_pkg

// [design/pps_tap_if.sv]
// Carrier between the pin selector and its scan controller
`timescale 1ns/1ns
interface pps_tap_if;
  logic                    tck_rise;
  logic                    tms;
  logic                    tap_rst_b;
  pps_pkg::pps_tap_state_t state;

  modport ctrl (input tck_rise, input tms, input tap_rst_b, output state);
  modport user (output tck_rise, output tms, output tap_rst_b, input state);
endinterface : pps_tap_if

// [design/pps_tap_fsm.sv]
// Scan controller state machine, advanced on detected scan clock rises
`timescale 1ns/1ns
module pps_tap_fsm (
  input  wire logic ref_clk_i,
  pps_tap_if.ctrl   tap
);

  pps_pkg::pps_tap_state_t state_ff;
  pps_pkg::pps_tap_state_t nxt_state;

  // ==========================================================================
  // Next state from the mode-select level
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      pps_pkg::TAP_RESET:    nxt_state = tap.tms ? pps_pkg::TAP_RESET   : pps_pkg::TAP_IDLE;
      pps_pkg::TAP_IDLE:     nxt_state = tap.tms ? pps_pkg::TAP_SEL_DR  : pps_pkg::TAP_IDLE;
      pps_pkg::TAP_SEL_DR:   nxt_state = tap.tms ? pps_pkg::TAP_SEL_IR  : pps_pkg::TAP_CAP_DR;
      pps_pkg::TAP_CAP_DR:   nxt_state = tap.tms ? pps_pkg::TAP_EXIT1_DR : pps_pkg::TAP_SHIFT_DR;
      pps_pkg::TAP_SHIFT_DR: nxt_state = tap.tms ? pps_pkg::TAP_EXIT1_DR : pps_pkg::TAP_SHIFT_DR;
      pps_pkg::TAP_EXIT1_DR: nxt_state = tap.tms ? pps_pkg::TAP_UPD_DR  : pps_pkg::TAP_PAUSE_DR;
      pps_pkg::TAP_PAUSE_DR: nxt_state = tap.tms ? pps_pkg::TAP_EXIT2_DR : pps_pkg::TAP_PAUSE_DR;
      pps_pkg::TAP_EXIT2_DR: nxt_state = tap.tms ? pps_pkg::TAP_UPD_DR  : pps_pkg::TAP_SHIFT_DR;
      pps_pkg::TAP_UPD_DR:   nxt_state = tap.tms ? pps_pkg::TAP_SEL_DR  : pps_pkg::TAP_IDLE;
      pps_pkg::TAP_SEL_IR:   nxt_state = tap.tms ? pps_pkg::TAP_RESET   : pps_pkg::TAP_CAP_IR;
      pps_pkg::TAP_CAP_IR:   nxt_state = tap.tms ? pps_pkg::TAP_EXIT1_IR : pps_pkg::TAP_SHIFT_IR;
      pps_pkg::TAP_SHIFT_IR: nxt_state = tap.tms ? pps_pkg::TAP_EXIT1_IR : pps_pkg::TAP_SHIFT_IR;
      pps_pkg::TAP_EXIT1_IR: nxt_state = tap.tms ? pps_pkg::TAP_UPD_IR  : pps_pkg::TAP_PAUSE_IR;
      pps_pkg::TAP_PAUSE_IR: nxt_state = tap.tms ? pps_pkg::TAP_EXIT2_IR : pps_pkg::TAP_PAUSE_IR;
      pps_pkg::TAP_EXIT2_IR: nxt_state = tap.tms ? pps_pkg::TAP_UPD_IR  : pps_pkg::TAP_SHIFT_IR;
      pps_pkg::TAP_UPD_IR:   nxt_state = tap.tms ? pps_pkg::TAP_SEL_DR  : pps_pkg::TAP_IDLE;
    endcase
  end

  // ==========================================================================
  // State register: moves only on a scan clock rise
  always_ff @(posedge ref_clk_i or negedge tap.tap_rst_b)
  begin
    if (!tap.tap_rst_b)
      state_ff <= pps_pkg::TAP_RESET;
    else if (tap.tck_rise)
      state_ff <= nxt_state;
  end

  assign tap.state = state_ff;

  upd_to_sel_a: assert property (@(posedge ref_clk_i) disable iff (!tap.tap_rst_b)
    tap.tck_rise && tap.tms && state_ff == pps_pkg::TAP_UPD_DR
      |=> state_ff == pps_pkg::TAP_SEL_DR)
    else $error("update state did not go to select on mode high");

endmodule : pps_tap_fsm

// [testbench/pps_scan_host.sv]
// Behavioural external scan controller and two-wire master
`timescale 1ns/1ns
module pps_scan_host (
  input  wire logic ref_clk_i,
  input  wire logic dout_i,
  input  wire logic dout_oe_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o
);
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end

  // ==========================================================
  // One 800 ns scan clock period; the clock stands low between calls
  task automatic clk(input logic tms, input logic tdi, output logic tdo, output logic oe);
    @(posedge ref_clk_i);
    tms_o <= tms;
    tdi_o <= tdi;
    repeat (3) @(posedge ref_clk_i);
    tck_o <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    // Output only moves after a fall, so it is settled late in the high phase
    // A released pin has no pull, so show the inverse rather than a stale level
    tdo = dout_oe_i ? dout_i : ~dout_i;
    oe = dout_oe_i;
    tck_o <= 1'b0;
  endtask : clk

  // Two-wire levels on the shared clock, data and mode pins
  task automatic wire_pins(input logic scl, input logic sda, input logic mode);
    @(posedge ref_clk_i);
    tck_o <= scl;
    tdi_o <= sda;
    tms_o <= mode;
  endtask : wire_pins

  task automatic tap_reset();
    logic t;
    logic o;
    repeat (5) clk(1'b1, 1'b0, t, o);
    clk(1'b0, 1'b0, t, o);
  endtask : tap_reset

  // From idle into the shift state of the instruction or data path
  task automatic enter(input logic is_ir);
    logic t;
    logic o;
    clk(1'b1, 1'b0, t, o);
    if (is_ir)
      clk(1'b1, 1'b0, t, o);
    clk(1'b0, 1'b0, t, o);
    clk(1'b0, 1'b0, t, o);
  endtask : enter

  // Shift n bits LSB first, then update and return to idle
  task automatic scan(input logic is_ir, input int n, input logic [7:0] din,
                      output logic [7:0] dout, output logic oe_all, output logic oe_upd);
    logic t;
    logic o;
    dout = 8'h00;
    oe_all = 1'b1;
    enter(is_ir);
    for (int i = 0; i < n; i++)
    begin
      clk(i == n - 1, din[i], t, o);
      dout[i] = t;
      oe_all = oe_all & o;
    end
    clk(1'b1, 1'b0, t, oe_upd);
    clk(1'b0, 1'b0, t, o);
  endtask : scan
endmodule : pps_scan_host

// [testbench/tb_prog_port_select_serial_pins.sv]
// Self-checking bench for the programming port pin selector
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin fail_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module tb_prog_port_select_serial_pins;
  logic       ref_clk_i;
  logic       rst_b;
  logic       sel;
  logic       scan_reset_b;
  logic [1:0] hi;
  logic       pull;
  wire logic  tck;
  wire logic  tms;
  wire logic  tdi;
  wire logic  din_w;
  logic       dout;
  logic       dout_oe;
  logic       sda_o;
  logic       sda_oe;
  logic       jtag;
  logic       scl;
  logic       sda;
  logic [2:0] addr;
  logic [7:0] cfg;
  logic       load;
  int         fail_count;
  int         samples_checked;
  int         cycles;
  int         load_cnt;
  logic [7:0] d;
  logic       oa;
  logic       oi;
  logic       t;
  // {scl, sda, mode, strap_hi, pull, exp scl, exp sda, exp addr, exp oe}
  logic [11:0] rows [5] = '{12'hc30, 12'h696, 12'h928, 12'h38a, 12'hf6b};

  // Open-drain data line with pull-up
  assign din_w = tdi & ~(sda_oe === 1'b1);

  pps_prog_port_select DUT (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b), .sel_i(sel), .scan_reset_b_i(scan_reset_b),
    .scan_clock_in_i(tck), .mode_pin_i(tms), .din_pin_i(din_w),
    .slave_addr_strap_hi_i(hi), .twi_sda_pull_i(pull), .dout_pin_o(dout),
    .dout_pin_oe_o(dout_oe), .sda_pin_o(sda_o), .sda_pin_oe_o(sda_oe), .jtag_mode_o(jtag),
    .twi_scl_o(scl), .twi_sda_o(sda), .slave_addr_o(addr), .cfg_data_o(cfg),
    .cfg_load_o(load));

  pps_scan_host host (
    .ref_clk_i(ref_clk_i), .dout_i(dout), .dout_oe_i(dout_oe),
    .tck_o(tck), .tms_o(tms), .tdi_o(tdi));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  always @(negedge ref_clk_i)
    if (load === 1'b1)
      load_cnt++;

  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fail_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  initial
  begin
    rst_b = 1'b0;
    sel = 1'b0;
    scan_reset_b = 1'b1;
    hi = 2'h0;
    pull = 1'b0;
    repeat (8) @(posedge ref_clk_i);
    `CHK("rst oe", 1'b0, dout_oe)
    `CHK("rst scl", 1'b1, scl)
    `CHK("rst addr", 3'h0, addr)
    `CHK("rst cfg", 8'h00, cfg)
    `CHK("rst jtag", 1'b0, jtag)
    rst_b <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    $display("test reset done");
    foreach (rows[i])
    begin
      host.wire_pins(rows[i][11], rows[i][10], rows[i][9]);
      hi <= rows[i][8:7];
      pull <= rows[i][6];
      repeat (8) @(posedge ref_clk_i);
      `CHK("scl", rows[i][5], scl)
      `CHK("sda", rows[i][4], sda)
      `CHK("addr", rows[i][3:1], addr)
      `CHK("sda oe", rows[i][0], sda_oe)
      `CHK("sda val", 1'b0, sda_o)
      `CHK("jtag", 1'b0, jtag)
      $display("test row %0d done", i);
    end
    host.wire_pins(1'b0, 1'b1, 1'b1);
    sel <= 1'b1;
    hi <= 2'h0;
    repeat (8) @(posedge ref_clk_i);
    `CHK("jtag", 1'b1, jtag)
    `CHK("scl", 1'b1, scl)
    `CHK("sda", 1'b1, sda)
    `CHK("sda oe", 1'b0, sda_oe)
    `CHK("addr", 3'h5, addr)
    $display("test scan select done");
    host.tap_reset();
    host.scan(1'b1, 4, 8'h02, d, oa, oi);
    `CHK("ir cap", 4'h1, d[3:0])
    `CHK("shift oe", 1'b1, oa)
    `CHK("idle oe", 1'b0, oi)
    host.scan(1'b0, 8, 8'ha5, d, oa, oi);
    `CHK("dr cap", pps_pkg::CFG_RST, d)
    `CHK("cfg", 8'ha5, cfg)
    `CHK("loads", 1, load_cnt)
    host.scan(1'b0, 8, 8'h3c, d, oa, oi);
    `CHK("dr back", 8'ha5, d)
    `CHK("cfg", 8'h3c, cfg)
    // Bypass path: one bit of delay, configuration left alone
    host.scan(1'b1, 4, 8'h0f, d, oa, oi);
    `CHK("ir cap2", 4'h1, d[3:0])
    host.scan(1'b0, 8, 8'h5a, d, oa, oi);
    `CHK("bypass", 8'hb4, d)
    `CHK("bypass oe", 1'b1, oa)
    `CHK("bypass cfg", 8'h3c, cfg)
    `CHK("bypass loads", 2, load_cnt)
    $display("test scan shift done");
    for (int k = 0; k < 2; k++)
    begin
      host.enter(1'b1);
      // Scan clock stands still: nothing may move on the reference clock alone
      repeat (20) @(posedge ref_clk_i);
      `CHK("hold oe", 1'b1, dout_oe)
      if (k == 0)
        sel <= 1'b0;
      else
        scan_reset_b <= 1'b0;
      repeat (6) @(posedge ref_clk_i);
      if (k == 0)
        `CHK("jtag", 1'b0, jtag)
      sel <= 1'b1;
      scan_reset_b <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      host.clk(1'b0, 1'b0, t, oa);
      host.clk(1'b0, 1'b0, t, oa);
      `CHK("reset oe", 1'b0, oa)
      `CHK("cfg kept", 8'h3c, cfg)
      $display("test scan reset %0d done", k);
    end
    stop_test();
  end
endmodule : tb_prog_port_select_serial_pins
